// *** pkg/bridge_defs.svh ***
// timing counts and reset values for the bridge gate controller
`ifndef BRIDGE_DEFS_SVH
`define BRIDGE_DEFS_SVH

// system clock
`define CLK_PERIOD_NS 20

// short circuit blanking time, rounded up to whole cycles
`define BLANK_TIME_NS 6000
`define BLANK_CYCLES ((`BLANK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// watchdog windows in oscillator ticks
`define WD_CLOSED_TICKS 16'h03D4
`define WD_OPEN_TICKS 16'h030C

// counts that depend on external parts, plain defaults
`define WD_RES_TICKS 16'h032C
`define WD_FIRST_TICKS 16'h9E88
`define WD_SHORT_TICKS 16'h0010
`define DEAD_TICKS 16'h0001

// synchroniser reset image: watchdog enable pulled up
`define SYNC_RST_VAL 19'h00002

`endif

// *** pkg/bridge_pkg.sv ***
// types shared by the bridge gate controller
package bridge_pkg;

    // watchdog and host reset sequencer states
    typedef enum logic [2:0] {
        WD_POWER,
        WD_INIT,
        WD_FIRST,
        WD_CLOSED,
        WD_OPEN,
        WD_SHORT,
        WD_DISABLED
    } wd_state_type;

endpackage

// *** core/sync_2ff.sv ***
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_sys_in,            // system clock
    input wire logic rstn_in,               // async reset, active low
    input wire logic [WIDTH-1:0] async_in,  // levels from pins
    output logic [WIDTH-1:0] sync_out       // levels in clock domain
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// *** core/short_blank_detect.sv ***
// per phase short detector with blanking after turn-on
`timescale 1ns/1ps
`include "bridge_defs.svh"
module short_blank_detect #(
    parameter int BLANK_CYCLES = `BLANK_CYCLES,
    parameter int CW = 9
) (
    input wire logic clk_sys_in,    // system clock
    input wire logic rstn_in,       // async reset, active low
    input wire logic phase_on_in,   // a gate of this phase is on
    input wire logic sense_in,      // drain sense over threshold
    output logic short_hit_out      // short detected, high while sense stays over threshold after blanking
);
    localparam logic [CW-1:0] LIMIT = CW'(BLANK_CYCLES);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic hit_q;
    logic hit_d;
    logic blank_done;

    // blanking restarts each time the phase turns on
    assign blank_done = (cnt_q == LIMIT);
    assign cnt_d = !phase_on_in ? '0 : (blank_done ? cnt_q : cnt_q + 1'b1);
    // sense is only trusted once blanking has run out
    assign hit_d = phase_on_in && blank_done && sense_in;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= '0;
            hit_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            hit_q <= hit_d;
        end
    end

    assign short_hit_out = hit_q;
endmodule

// *** core/bridge_gate_control.sv ***
// three-phase gate control with window watchdog and host reset
//
// Contract
// - watchdog on while enable pin high; pulled up so default on
// - sleep mode stops the watchdog completely
// - host reset held for timeout after host supply exceeds 88 percent
// - first kick must arrive within first window, else reset again
// - after first kick: closed then open window, missed kick gives pulse
// - kick inside closed window also gives short reset pulse
// - each cycle starts at latest kick or reset rising edge
// - watchdog disabled: only the initial timeout reset
// - host reset asserted while host supply below 80 percent
// - closed window 980 ticks, open window 780 ticks
// - supply flag raised when pump good missing or lost
// - per phase 1/0 low on, 0/1 high on, else both off
// - gates only with active mode, kick seen if watchdog on, supplies, pump, temp ok
// - sense still high after 6 us blanking: all off, short flag
// - any command rising edge clears short flag, re-enables gates
// - after any gate turns off, block all turn-on until dead time ends
// - any command falling edge restarts the dead time
// - dead time lockout also applies after short circuit shutdown
// - bridge supply over or under voltage: gates off, supply flag
`timescale 1ns/1ps
`include "bridge_defs.svh"
module bridge_gate_control #(
    parameter logic [15:0] RES_TICKS = `WD_RES_TICKS,
    parameter logic [15:0] FIRST_TICKS = `WD_FIRST_TICKS,
    parameter logic [15:0] SHORT_TICKS = `WD_SHORT_TICKS,
    parameter logic [15:0] DEAD_TICKS = `DEAD_TICKS,
    parameter logic [15:0] CLOSED_TICKS = `WD_CLOSED_TICKS,
    parameter logic [15:0] OPEN_TICKS = `WD_OPEN_TICKS,
    parameter int BLANK_CYCLES = `BLANK_CYCLES
) (
    input wire logic clk_sys_in,                  // 50 MHz system clock
    input wire logic rstn_in,                     // async reset, active low
    input wire logic tick_in,                     // oscillator tick level
    input wire logic watchdog_gate_pin_in,        // watchdog enable
    input wire logic watchdog_kick_in,            // watchdog trigger
    input wire logic [2:0] low_side_command_in,   // low commands
    input wire logic [2:0] high_side_command_in,  // high commands
    input wire logic [2:0] drain_sense_in,        // short comparators
    input wire logic sleep_mode_in,               // device in sleep
    input wire logic host_supply_ok_in,           // host supply over 88%
    input wire logic host_supply_low_in,          // host supply under 80%
    input wire logic bridge_ov_in,                // bridge supply over
    input wire logic bridge_uv_in,                // bridge supply under
    input wire logic pump_good_level_in,          // charge pump good
    input wire logic overtemp_in,                 // thermal shutdown
    output logic [2:0] low_gate_out,              // low gate drives
    output logic [2:0] high_gate_out,             // high gate drives
    output logic host_reset_n_out,                // host reset, active low
    output logic short_fault_flag_out,            // short flag
    output logic supply_fault_flag_out            // supply flag
);
    import bridge_pkg::*;

    // ****************************************
    // input synchronisation
    // ****************************************
    logic [18:0] pins;
    logic [18:0] syn;
    logic tick, wd_en, kick;
    logic [2:0] cmd_l, cmd_h, sense;
    logic sleep, vcc_ok, vcc_low, bat_ov, bat_uv, pump_good, hot;

    assign pins = {overtemp_in, pump_good_level_in, bridge_uv_in, bridge_ov_in,
                   host_supply_low_in, host_supply_ok_in, sleep_mode_in,
                   drain_sense_in, high_side_command_in, low_side_command_in,
                   watchdog_kick_in, watchdog_gate_pin_in, tick_in};

    // enable resets high so an undriven pin means watchdog on
    sync_2ff #(.WIDTH(19), .RST_VAL(`SYNC_RST_VAL)) u_sync (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .async_in(pins),
        .sync_out(syn)
    );

    // named views of the synchronised vector, same order as the pin vector
    assign {hot, pump_good, bat_uv, bat_ov, vcc_low, vcc_ok, sleep,
            sense, cmd_h, cmd_l, kick, wd_en, tick} = syn;

    // ****************************************
    // edge detection
    // ****************************************
    logic tick_prev_q;
    logic kick_prev_q;
    logic [5:0] cmd_prev_q;
    logic [5:0] cmd_now;
    logic tick_rise, kick_rise, cmd_rise, cmd_fall;

    assign cmd_now = {cmd_h, cmd_l};
    assign tick_rise = tick && !tick_prev_q;
    assign kick_rise = kick && !kick_prev_q;
    assign cmd_rise = |(cmd_now & ~cmd_prev_q);
    assign cmd_fall = |(~cmd_now & cmd_prev_q);

    // previous levels, compared against synchronised values only
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tick_prev_q <= 1'b0;
            kick_prev_q <= 1'b0;
            cmd_prev_q <= 6'h00;
        end else begin
            tick_prev_q <= tick;
            kick_prev_q <= kick;
            cmd_prev_q <= cmd_now;
        end
    end

    // ****************************************
    // watchdog and host reset sequencer
    // ****************************************
    wd_state_type state_q;
    wd_state_type state_d;
    logic armed_q;
    logic armed_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [15:0] lim;
    logic lim_hit;
    logic power_bad;
    logic rst_n_q;
    logic rst_n_d;

    // window lengths per state
    assign lim = (state_q == WD_INIT) ? RES_TICKS :
                 (state_q == WD_FIRST) ? FIRST_TICKS :
                 (state_q == WD_CLOSED) ? CLOSED_TICKS :
                 (state_q == WD_OPEN) ? OPEN_TICKS :
                 (state_q == WD_SHORT) ? SHORT_TICKS : 16'h0001;
    assign lim_hit = tick_rise && (cnt_q == lim - 16'h0001);
    // sleep or a sagging host supply parks the sequencer
    assign power_bad = sleep || vcc_low || !vcc_ok;
    // every state change restarts the window count
    assign cnt_d = (state_d != state_q) ? 16'h0000 :
                   (tick_rise ? cnt_q + 16'h0001 : cnt_q);

    // sequencer next state
    always_comb begin
        state_d = state_q;
        armed_d = armed_q;
        if (power_bad) begin
            state_d = WD_POWER;
            armed_d = 1'b0;
        end else begin
            case (state_q)
                WD_POWER: begin
                    state_d = WD_INIT;
                end
                WD_INIT: begin
                    if (lim_hit) begin
                        state_d = wd_en ? WD_FIRST : WD_DISABLED;
                    end
                end
                WD_DISABLED: begin
                    if (wd_en) begin
                        state_d = WD_FIRST;
                    end
                end
                WD_FIRST: begin
                    if (!wd_en) begin
                        state_d = WD_DISABLED;
                    end else if (kick_rise) begin
                        state_d = WD_CLOSED;
                        armed_d = 1'b1;
                    end else if (lim_hit) begin
                        state_d = WD_SHORT;
                    end
                end
                WD_CLOSED: begin
                    if (!wd_en) begin
                        state_d = WD_DISABLED;
                    end else if (kick_rise) begin
                        state_d = WD_SHORT;
                    end else if (lim_hit) begin
                        state_d = WD_OPEN;
                    end
                end
                WD_OPEN: begin
                    if (!wd_en) begin
                        state_d = WD_DISABLED;
                    end else if (kick_rise) begin
                        state_d = WD_CLOSED;
                    end else if (lim_hit) begin
                        state_d = WD_SHORT;
                    end
                end
                WD_SHORT: begin
                    if (lim_hit) begin
                        // reset rising edge opens a fresh cycle
                        state_d = armed_q ? WD_CLOSED : WD_FIRST;
                    end
                end
                default: begin
                    state_d = WD_POWER;
                end
            endcase
        end
    end

    // reset output low while parked, timing out, or pulsing
    assign rst_n_d = !((state_d == WD_POWER) || (state_d == WD_INIT) ||
                       (state_d == WD_SHORT));

    // sequencer registers
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= WD_POWER;
            armed_q <= 1'b0;
            cnt_q <= 16'h0000;
            rst_n_q <= 1'b0;
        end else begin
            state_q <= state_d;
            armed_q <= armed_d;
            cnt_q <= cnt_d;
            rst_n_q <= rst_n_d;
        end
    end

    // ****************************************
    // gate path: mapping, enable, dead time, short
    // ****************************************
    logic [2:0] req_l;
    logic [2:0] req_h;
    logic [5:0] gate_q;
    logic [5:0] gate_d;
    logic [5:0] gate_fall, gate_req;
    logic drive_ok, turn_on_ok;
    logic bridge_ok;
    logic [15:0] dead_q;
    logic [15:0] dead_d;
    logic dead_busy;
    logic [2:0] hit;
    logic short_q;
    logic short_d;
    logic supply_q;
    logic supply_d;

    // both high or both low turns the phase off
    assign req_l = cmd_l & ~cmd_h;
    assign req_h = cmd_h & ~cmd_l;
    assign bridge_ok = !bat_ov && !bat_uv && pump_good;
    // gating conditions; armed only matters with watchdog on
    assign drive_ok = !sleep && (armed_q || !wd_en) && bridge_ok && !hot && !short_q;
    assign dead_busy = (dead_q != 16'h0000);
    // a gate already on may stay on; an off gate waits for dead time
    // turn-on also waits while a gate or command falls, so a swap never lands on one edge
    assign gate_req = {req_h, req_l} & {6{drive_ok}};
    assign gate_fall = gate_q & ~gate_req;
    assign turn_on_ok = !dead_busy && !cmd_fall && !(|gate_fall);
    assign gate_d = gate_req & (gate_q | {6{turn_on_ok}});
    // restart on any gate falling, including short shutdown
    assign dead_d = (cmd_fall || (|gate_fall)) ? DEAD_TICKS :
                    ((dead_busy && tick_rise) ? dead_q - 16'h0001 : dead_q);
    // new short wins over a clearing edge in the same cycle
    assign short_d = (|hit) || (short_q && !cmd_rise);
    // pump missing or lost, or bridge supply out of range
    assign supply_d = !bridge_ok;

    // blanking detectors, one per phase
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_phase
            short_blank_detect #(.BLANK_CYCLES(BLANK_CYCLES), .CW(9)) u_det (
                .clk_sys_in(clk_sys_in),
                .rstn_in(rstn_in),
                .phase_on_in(gate_q[p] || gate_q[p+3]),
                .sense_in(sense[p]),
                .short_hit_out(hit[p])
            );
        end
    endgenerate

    // gate, dead time and flag registers
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            gate_q <= 6'h00;
            dead_q <= 16'h0000;
            short_q <= 1'b0;
            supply_q <= 1'b0;
        end else begin
            gate_q <= gate_d;
            dead_q <= dead_d;
            short_q <= short_d;
            supply_q <= supply_d;
        end
    end

    assign low_gate_out = gate_q[2:0];
    assign high_gate_out = gate_q[5:3];
    assign host_reset_n_out = rst_n_q;
    assign short_fault_flag_out = short_q;
    assign supply_fault_flag_out = supply_q;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    a_phase_interlock: assert property ((gate_q[2:0] & gate_q[5:3]) == 3'h0)
        else $error("low and high gate on together");
    a_gate_mapping: assert property ((gate_q & ~$past({req_h, req_l})) == 6'h00)
        else $error("gate on without matching command");
    a_gate_enable: assert property (!drive_ok |=> gate_q == 6'h00)
        else $error("gate on while drive not allowed");
    a_short_shutdown: assert property (|hit |=> short_q ##1 gate_q == 6'h00)
        else $error("short did not shut gates and set flag");
    a_short_clear: assert property (short_q && cmd_rise && !(|hit) |=> !short_q)
        else $error("command edge did not clear short flag");
    a_dead_block: assert property (dead_busy |=> (gate_q & ~$past(gate_q)) == 6'h00)
        else $error("gate turned on during dead time");
    a_gate_swap: assert property (!((|gate_fall) && (|(gate_d & ~gate_q))))
        else $error("gate turned on while another turned off");
    a_dead_restart: assert property (cmd_fall |=> dead_q == DEAD_TICKS)
        else $error("dead time not restarted");
    a_sleep_stop: assert property (sleep |=> state_q == WD_POWER && !armed_q)
        else $error("watchdog runs in sleep");
    a_low_reset: assert property (vcc_low |=> !host_reset_n_out)
        else $error("no reset on low host supply");
    a_closed_kick: assert property (state_q == WD_CLOSED && kick_rise && wd_en && !power_bad
                                    |=> state_q == WD_SHORT ##1 !host_reset_n_out)
        else $error("early kick did not pulse reset");
    a_disabled_quiet: assert property (state_q == WD_DISABLED |-> host_reset_n_out)
        else $error("reset while watchdog disabled");
    a_supply_flag: assert property ($rose(bat_ov) |=> supply_fault_flag_out)
        else $error("overvoltage not flagged");

    c_open_window: cover property (state_q == WD_CLOSED ##1 state_q == WD_OPEN);
    c_short_pulse: cover property (state_q == WD_OPEN ##1 state_q == WD_SHORT);
    c_short_fault: cover property (short_q ##1 !short_q);
    c_dead_hold: cover property (dead_busy && |(gate_d ^ {req_h, req_l}));
endmodule

// *** sim/host_mcu_model.sv ***
// host microcontroller model driving phase commands and watchdog kicks
`timescale 1ns/1ps
module host_mcu_model (
    input wire logic clk_sys_in,               // system clock
    output logic [2:0] low_side_command_out,   // low commands
    output logic [2:0] high_side_command_out,  // high commands
    output logic watchdog_kick_out             // watchdog trigger
);
    // pins idle low, as the pull-downs would leave them
    initial begin
        low_side_command_out = 3'h0;
        high_side_command_out = 3'h0;
        watchdog_kick_out = 1'b0;
    end
    // commands change just after an edge; a rising bit clears a short
    task automatic set_cmd(input logic [2:0] lo, input logic [2:0] hi);
        @(posedge clk_sys_in);
        #1;
        low_side_command_out = lo;
        high_side_command_out = hi;
    endtask
    // held four cycles so the synchroniser sees one clean rising edge
    task automatic kick();
        @(posedge clk_sys_in);
        #1;
        watchdog_kick_out = 1'b1;
        repeat (4) @(posedge clk_sys_in);
        #1;
        watchdog_kick_out = 1'b0;
    endtask
endmodule

// *** sim/tb.sv ***
// self-checking testbench for the bridge gate controller
`timescale 1ns/1ps
module tb;
    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic wd_pin = 1'b1;
    logic [2:0] sense = 3'h0;
    logic sleep = 1'b0;
    logic sup_ok = 1'b1;
    logic sup_low = 1'b0;
    logic [3:0] fault = 4'h0;
    logic [1:0] tdiv = 2'h0;
    logic watch_rst = 1'b0;
    wire [2:0] lo_cmd;
    wire [2:0] hi_cmd;
    wire kick_w;
    wire [2:0] lo_g;
    wire [2:0] hi_g;
    wire rst_n;
    wire sc_flag;
    wire sup_flag;
    int fails = 0;
    int check_count = 0;
    int rst_lows = 0;

    // ************************************************
    // clock, tick, instances
    // ************************************************
    always #10 clk_sys_in = ~clk_sys_in;
    // one tick every four cycles keeps the windows short
    always @(posedge clk_sys_in) begin
        #1;
        tdiv = tdiv + 2'h1;
    end
    // counts host resets while the watchdog should be silent; negedge keeps clear of the launch edge
    always @(negedge clk_sys_in) begin
        if (watch_rst && rst_n !== 1'b1) rst_lows++;
    end

    host_mcu_model i_host_mcu_model (
        .clk_sys_in(clk_sys_in),
        .low_side_command_out(lo_cmd),
        .high_side_command_out(hi_cmd),
        .watchdog_kick_out(kick_w)
    );
    bridge_gate_control #(
        .RES_TICKS(16'h0004), .FIRST_TICKS(16'h0008), .DEAD_TICKS(16'h0002),
        .CLOSED_TICKS(16'h0006), .OPEN_TICKS(16'h0005)
    ) i_bridge_gate_control (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .tick_in(tdiv[1]),
        .watchdog_gate_pin_in(wd_pin), .watchdog_kick_in(kick_w),
        .low_side_command_in(lo_cmd), .high_side_command_in(hi_cmd), .drain_sense_in(sense),
        .sleep_mode_in(sleep), .host_supply_ok_in(sup_ok), .host_supply_low_in(sup_low),
        .bridge_ov_in(fault[1]), .bridge_uv_in(fault[2]), .pump_good_level_in(~fault[0]),
        .overtemp_in(fault[3]), .low_gate_out(lo_g), .high_gate_out(hi_g),
        .host_reset_n_out(rst_n), .short_fault_flag_out(sc_flag), .supply_fault_flag_out(sup_flag)
    );

    // ************************************************
    // helpers
    // ************************************************
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // waits for the host reset level and checks how long it took
    task automatic wait_rst(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (rst_n !== v && n <= hi) begin
            step(1);
            n++;
        end
        check("rst_time", 32'(n >= lo && n <= hi), 32'h1);
    endtask
    task automatic finish_test();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #200000;
        fails++;
        finish_test();
    end

    // ************************************************
    // tests
    // ************************************************
    initial begin
        repeat (8) @(posedge clk_sys_in);
        #1;
        rstn_in = 1'b1;
        wait_rst(1'b1, 12, 30);
        i_host_mcu_model.set_cmd(3'h1, 3'h0);
        step(6);
        check("low_gate", 32'(lo_g), 32'h0);
        wait_rst(1'b0, 15, 40);
        wait_rst(1'b1, 58, 70);
        i_host_mcu_model.kick();
        step(4);
        check("low_gate", 32'(lo_g), 32'h1);
        step(4);
        i_host_mcu_model.kick();
        wait_rst(1'b0, 0, 10);
        wait_rst(1'b1, 58, 70);
        step(30);
        i_host_mcu_model.kick();
        wait_rst(1'b0, 35, 55);
        wait_rst(1'b1, 58, 70);
        // watchdog off from here: no host reset may appear
        wd_pin = 1'b0;
        step(4);
        watch_rst = 1'b1;
        for (int p = 0; p < 3; p++) begin
            for (int c = 0; c < 4; c++) begin
                i_host_mcu_model.set_cmd(3'((c & 1) << p), 3'((c >> 1) << p));
                step(16);
                check("low_gate", 32'(lo_g), 32'((c == 1) << p));
                check("high_gate", 32'(hi_g), 32'((c == 2) << p));
            end
        end
        // swap low to high on one phase: turn-on waits for the dead time
        i_host_mcu_model.set_cmd(3'h1, 3'h0);
        step(16);
        i_host_mcu_model.set_cmd(3'h0, 3'h1);
        step(5);
        check("high_gate", 32'(hi_g), 32'h0);
        step(16);
        check("high_gate", 32'(hi_g), 32'h1);
        // short after turn-on: blanking first, then latch and shutdown
        i_host_mcu_model.set_cmd(3'h0, 3'h0);
        step(16);
        i_host_mcu_model.set_cmd(3'h1, 3'h0);
        sense = 3'h1;
        step(290);
        check("low_gate", 32'(lo_g), 32'h1);
        check("short_flag", 32'(sc_flag), 32'h0);
        step(20);
        check("short_flag", 32'(sc_flag), 32'h1);
        check("low_gate", 32'(lo_g), 32'h0);
        sense = 3'h0;
        i_host_mcu_model.set_cmd(3'h1, 3'h2);
        step(16);
        check("short_flag", 32'(sc_flag), 32'h0);
        check("gates", 32'({hi_g, lo_g}), 32'h11);
        // pump, over, under voltage and overtemperature each stop the gates
        for (int i = 0; i < 4; i++) begin
            fault = 4'(1 << i);
            step(6);
            check("low_gate", 32'(lo_g), 32'h0);
            check("supply_flag", 32'(sup_flag), 32'(i < 3));
            fault = 4'h0;
            step(16);
            check("low_gate", 32'(lo_g), 32'h1);
        end
        check("rst_lows", 32'(rst_lows), 32'h0);
        watch_rst = 1'b0;
        sleep = 1'b1;
        step(6);
        check("host_reset", 32'(rst_n), 32'h0);
        check("low_gate", 32'(lo_g), 32'h0);
        sleep = 1'b0;
        wait_rst(1'b1, 12, 30);
        sup_low = 1'b1;
        step(5);
        check("host_reset", 32'(rst_n), 32'h0);
        sup_low = 1'b0;
        wait_rst(1'b1, 0, 40);
        wd_pin = 1'b1;
        wait_rst(1'b0, 20, 45);
        finish_test();
    end
endmodule
